/* File: verilog/pir_adv_pkg.sv */
/*
 * Constants of the motion engine advanced register set: register indices,
 * field positions, bus answers and counts for the white-light logic.
 * Assumes a 32-bit AXI4-Lite bus with one register per aligned word.
 */
package pir_adv_pkg;
   // ----------------------------------------
   // Register indices (byte address = 4 * index)
   // ----------------------------------------
   localparam logic [7:0] IDX_CTL0 = 8'hF0;
   localparam logic [7:0] IDX_WLT = 8'hF1;
   localparam logic [7:0] IDX_WIN = 8'hF2;
   localparam logic [7:0] IDX_CAP_H = 8'hF3;
   localparam logic [7:0] IDX_CAP_L = 8'hF4;
   localparam logic [7:0] IDX_AVG = 8'hF5;
   localparam logic [7:0] IDX_DBT = 8'hF6;
   localparam logic [7:0] IDX_DBM = 8'hF7;
   localparam logic [7:0] IDX_TRS = 8'hF8;
   localparam logic [7:0] IDX_NOI = 8'hF9;
   localparam logic [7:0] IDX_SMP_H = 8'hFA;
   localparam logic [7:0] IDX_SMP_L = 8'hFB;
   localparam logic [7:0] IDX_DC_H = 8'hFC;
   localparam logic [7:0] IDX_DC_L = 8'hFD;
   localparam logic [7:0] IDX_EXS = 8'hFE;
   localparam logic [7:0] IDX_EXT = 8'hFF;
   localparam logic [7:0] IDX_REV = 8'hEF;
   // ----------------------------------------
   // Control register 0 bits
   // ----------------------------------------
   localparam int B_VREF = 7;
   localparam int B_WLDET = 6;
   localparam int B_JAM = 5;
   localparam int B_REFR = 4;
   localparam int B_NEW = 3;
   localparam int B_ORIG = 2;
   localparam int B_NOISE = 1;
   localparam int B_TRANS = 0;
   localparam logic [7:0] CTL0_FLAGS = 8'h4B;
   // ----------------------------------------
   // Reset values, sensitivity readback mask and bus answers
   // ----------------------------------------
   localparam logic [7:0] CFG_RESET = 8'h00;
   localparam logic [7:0] SENS_MASK = 8'h7F;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // ----------------------------------------
   // White-light counts, in constructed samples except JAM_EVENTS, in events
   // ----------------------------------------
   localparam logic [7:0] WL_SCAN_STEP = 8'h05;
   localparam logic [3:0] JAM_EVENTS = 4'hC;
   localparam logic [15:0] JAM_WINDOW = 16'h0064;
   localparam logic [15:0] JAM_QUIET = 16'h00C8;
endpackage : pir_adv_pkg

/* File: verilog/pir_adv_regs.sv */
/*
 * Advanced register set of the motion engine with its white-light
 * scan, debounce and anti-jam logic, reached over AXI4-Lite.
 * Assumes engine-side inputs come from logic on aclk.
 */
// Our own choice: the AXI4-Lite slave port.
`timescale 1ns/1ps
// What this block does
// - Read-only revision byte, writes ignored
// - Engine init never loads configuration defaults
// - Bit 7 selects external ADC reference
// - Bit 6 flags white-light event, software clears
// - Anti-jam ignores events after twelve quickly
// - Refresh bit at init refills sample buffers
// - Bit 3 flags new sample, software clears
// - Bit 2 records which detector fired
// - Bit 0 flags transient, software clears
// - Bits 7-4 set white-light debounce count
// - Bits 3-0 set scan interval, steps of five
// - Publish 16-bit processing capacity indicator
// - Byte at F5h sets sample averaging
// - Byte at F7h sets out-of-window mask
// - Expose latest sensor sample, 16 bits
// - Expose sensor DC offset, 16 bits
module pir_adv_regs #(
   parameter int ADDR_W = 10,
   parameter logic [7:0] REVISION = 8'h5A // Arbitrary value
) (
   // Clock, reset, enable
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic ce,
   // AXI4-Lite write
   input wire logic [ADDR_W-1:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   // AXI4-Lite read
   input wire logic [ADDR_W-1:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   // Engine events and values
   input wire logic engine_init,
   input wire logic constructed_sample,
   input wire logic wl_result_valid,
   input wire logic wl_above_threshold,
   input wire logic wl_threshold_zero,
   input wire logic sample_valid,
   input wire logic [15:0] sample_in,
   input wire logic [15:0] dc_offset_in,
   input wire logic [15:0] capacity_in,
   input wire logic motion_detect,
   input wire logic motion_extended,
   input wire logic transient_event,
   input wire logic noise_event,
   // Engine controls
   output logic vref_external,
   output logic vref_internal_1v,
   output logic buffer_refresh,
   output logic wl_scan,
   output logic wl_event,
   output logic wl_jammed,
   output logic [7:0] window_lock_control,
   output logic [7:0] sample_averaging_amount,
   output logic [7:0] motion_debounce_time,
   output logic [7:0] debounce_out_of_window_mask,
   output logic [6:0] transient_sensitivity_level,
   output logic [6:0] noise_sensitivity_level,
   output logic [7:0] extended_detector_sensitivity,
   output logic [7:0] extended_detector_timeout
);
   // ----------------------------------------
   // State
   // ----------------------------------------
   typedef struct packed {
      logic awready;
      logic wready;
      logic arready;
      logic bvalid;
      logic rvalid;
      logic aw_got;
      logic w_got;
      logic [7:0] aw_idx;
      logic [7:0] w_byte;
      logic w_lane;
      logic [7:0] ar_idx;
      logic [1:0] bresp;
      logic [1:0] rresp;
      logic [7:0] rdata;
      logic [7:0] ctl0;
      logic [7:0] wlt;
      logic [7:0] win;
      logic [7:0] avg;
      logic [7:0] dbt;
      logic [7:0] dbm;
      logic [6:0] trs;
      logic [6:0] noi;
      logic [7:0] exs;
      logic [7:0] ext;
      logic [15:0] smp;
      logic [15:0] dc;
      logic [15:0] cap;
      logic vref_int;
      logic refresh;
      logic scan;
      logic event_p;
      logic [7:0] scan_cnt;
      logic [3:0] run;
      logic [3:0] jam_cnt;
      logic [15:0] jam_win;
      logic jam;
      logic [15:0] quiet;
   } state_t;

   state_t s_q;
   state_t s_d;

   logic [7:0] aw_idx_in;
   logic [7:0] ar_idx_in;
   logic [7:0] rd_byte;
   logic rd_ok;
   logic wr_ok;
   logic [7:0] set0;
   logic [7:0] scan_len;
   logic [3:0] db_need;
   logic raw_event;

   assign aw_idx_in = awaddr[9:2];
   assign ar_idx_in = araddr[9:2];

   // ----------------------------------------
   // Read decode
   // ----------------------------------------
   always_comb begin
      rd_ok = 1'b1;
      unique case (ar_idx_in)
         pir_adv_pkg::IDX_REV: rd_byte = REVISION;
         pir_adv_pkg::IDX_CTL0: rd_byte = s_q.ctl0;
         pir_adv_pkg::IDX_WLT: rd_byte = s_q.wlt;
         pir_adv_pkg::IDX_WIN: rd_byte = s_q.win;
         pir_adv_pkg::IDX_CAP_H: rd_byte = s_q.cap[15:8];
         pir_adv_pkg::IDX_CAP_L: rd_byte = s_q.cap[7:0];
         pir_adv_pkg::IDX_AVG: rd_byte = s_q.avg;
         pir_adv_pkg::IDX_DBT: rd_byte = s_q.dbt;
         pir_adv_pkg::IDX_DBM: rd_byte = s_q.dbm;
         pir_adv_pkg::IDX_TRS: rd_byte = {1'b0, s_q.trs};
         pir_adv_pkg::IDX_NOI: rd_byte = {1'b0, s_q.noi};
         pir_adv_pkg::IDX_SMP_H: rd_byte = s_q.smp[15:8];
         pir_adv_pkg::IDX_SMP_L: rd_byte = s_q.smp[7:0];
         pir_adv_pkg::IDX_DC_H: rd_byte = s_q.dc[15:8];
         pir_adv_pkg::IDX_DC_L: rd_byte = s_q.dc[7:0];
         pir_adv_pkg::IDX_EXS: rd_byte = s_q.exs;
         pir_adv_pkg::IDX_EXT: rd_byte = s_q.ext;
         default: begin
            rd_byte = 8'h00;
            rd_ok = 1'b0;
         end
      endcase
   end

   // ----------------------------------------
   // Next state
   // ----------------------------------------
   always_comb begin
      s_d = s_q;
      s_d.refresh = 1'b0;
      s_d.scan = 1'b0;
      s_d.event_p = 1'b0;
      set0 = 8'h00;
      wr_ok = 1'b0;
      raw_event = 1'b0;
      scan_len = 8'((32'(s_q.wlt[3:0]) + 1) * 32'(pir_adv_pkg::WL_SCAN_STEP));
      db_need = (s_q.wlt[7:4] == 4'h0) ? 4'h1 : s_q.wlt[7:4];

      // Bus write channel capture
      if (awvalid && s_q.awready) begin
         s_d.aw_got = 1'b1;
         s_d.aw_idx = aw_idx_in;
      end
      if (wvalid && s_q.wready) begin
         s_d.w_got = 1'b1;
         s_d.w_byte = wdata[7:0];
         s_d.w_lane = wstrb[0];
      end
      if (s_q.bvalid && bready) begin
         s_d.bvalid = 1'b0;
      end

      // Engine status and values
      s_d.cap = capacity_in;
      s_d.dc = dc_offset_in;
      if (sample_valid) begin
         s_d.smp = sample_in;
         set0[pir_adv_pkg::B_NEW] = 1'b1;
      end
      if (transient_event) begin
         set0[pir_adv_pkg::B_TRANS] = 1'b1;
      end
      if (noise_event) begin
         set0[pir_adv_pkg::B_NOISE] = 1'b1;
      end
      if (motion_detect) begin
         s_d.ctl0[pir_adv_pkg::B_ORIG] = motion_extended;
      end
      if (engine_init) begin
         // Configuration is left as software wrote it
         s_d.vref_int = 1'b1;
         s_d.refresh = s_q.ctl0[pir_adv_pkg::B_REFR];
      end

      // White-light scan pacing
      if (constructed_sample) begin
         if (s_q.scan_cnt + 8'h01 >= scan_len) begin
            s_d.scan_cnt = 8'h00;
            s_d.scan = !wl_threshold_zero;
         end else begin
            s_d.scan_cnt = s_q.scan_cnt + 8'h01;
         end
      end

      // White-light debounce
      if (wl_result_valid) begin
         if (wl_above_threshold && !wl_threshold_zero) begin
            if (s_q.run + 4'h1 >= db_need) begin
               raw_event = 1'b1;
               s_d.run = 4'h0;
            end else begin
               s_d.run = s_q.run + 4'h1;
            end
         end else begin
            s_d.run = 4'h0;
         end
      end

      // Anti-jam
      if (raw_event && !s_q.jam) begin
         s_d.event_p = 1'b1;
         set0[pir_adv_pkg::B_WLDET] = 1'b1;
         if (s_q.ctl0[pir_adv_pkg::B_JAM]) begin
            if (s_q.jam_cnt + 4'h1 >= pir_adv_pkg::JAM_EVENTS) begin
               s_d.jam = 1'b1;
               s_d.jam_cnt = 4'h0;
               s_d.quiet = 16'h0000;
            end else begin
               s_d.jam_cnt = s_q.jam_cnt + 4'h1;
            end
            if (s_q.jam_cnt == 4'h0) begin
               s_d.jam_win = 16'h0000;
            end
         end
      end else if (constructed_sample && s_q.jam_cnt != 4'h0) begin
         if (s_q.jam_win + 16'h0001 >= pir_adv_pkg::JAM_WINDOW) begin
            s_d.jam_cnt = 4'h0;
         end else begin
            s_d.jam_win = s_q.jam_win + 16'h0001;
         end
      end
      if (s_q.jam) begin
         if (raw_event) begin
            s_d.quiet = 16'h0000;
         end else if (constructed_sample) begin
            if (s_q.quiet + 16'h0001 >= pir_adv_pkg::JAM_QUIET) begin
               s_d.jam = 1'b0;
            end else begin
               s_d.quiet = s_q.quiet + 16'h0001;
            end
         end
         if (!s_q.ctl0[pir_adv_pkg::B_JAM]) begin
            s_d.jam = 1'b0;
         end
      end

      // Register write once both channels are in
      if (s_d.aw_got && s_d.w_got && !s_q.bvalid) begin
         s_d.aw_got = 1'b0;
         s_d.w_got = 1'b0;
         s_d.bvalid = 1'b1;
         wr_ok = s_d.w_lane;
         s_d.bresp = pir_adv_pkg::RESP_OKAY;
         unique case (s_d.aw_idx)
            pir_adv_pkg::IDX_CTL0: begin
               // Flags only clear; engine sets win over clears
               s_d.ctl0[7] = wr_ok ? s_d.w_byte[7] : s_q.ctl0[7];
               s_d.ctl0[5:4] = wr_ok ? s_d.w_byte[5:4] : s_q.ctl0[5:4];
               if (wr_ok) begin
                  s_d.ctl0 = s_d.ctl0 & ~(pir_adv_pkg::CTL0_FLAGS & ~s_d.w_byte);
               end
            end
            pir_adv_pkg::IDX_WLT: s_d.wlt = wr_ok ? s_d.w_byte : s_q.wlt;
            pir_adv_pkg::IDX_WIN: s_d.win = wr_ok ? s_d.w_byte : s_q.win;
            pir_adv_pkg::IDX_AVG: s_d.avg = wr_ok ? s_d.w_byte : s_q.avg;
            pir_adv_pkg::IDX_DBT: s_d.dbt = wr_ok ? s_d.w_byte : s_q.dbt;
            pir_adv_pkg::IDX_DBM: s_d.dbm = wr_ok ? s_d.w_byte : s_q.dbm;
            pir_adv_pkg::IDX_TRS: s_d.trs = wr_ok ? s_d.w_byte[6:0] : s_q.trs;
            pir_adv_pkg::IDX_NOI: s_d.noi = wr_ok ? s_d.w_byte[6:0] : s_q.noi;
            pir_adv_pkg::IDX_EXS: s_d.exs = wr_ok ? s_d.w_byte : s_q.exs;
            pir_adv_pkg::IDX_EXT: s_d.ext = wr_ok ? s_d.w_byte : s_q.ext;
            pir_adv_pkg::IDX_REV, pir_adv_pkg::IDX_CAP_H, pir_adv_pkg::IDX_CAP_L,
            pir_adv_pkg::IDX_SMP_H, pir_adv_pkg::IDX_SMP_L,
            pir_adv_pkg::IDX_DC_H, pir_adv_pkg::IDX_DC_L: begin
               s_d.bresp = pir_adv_pkg::RESP_OKAY;
            end
            default: s_d.bresp = pir_adv_pkg::RESP_SLVERR;
         endcase
      end
      s_d.ctl0 = s_d.ctl0 | set0;

      // Read channel
      if (s_q.rvalid && rready) begin
         s_d.rvalid = 1'b0;
      end
      if (arvalid && s_q.arready) begin
         s_d.rvalid = 1'b1;
         s_d.ar_idx = ar_idx_in;
         s_d.rdata = rd_byte;
         s_d.rresp = rd_ok ? pir_adv_pkg::RESP_OKAY : pir_adv_pkg::RESP_SLVERR;
      end
      s_d.awready = !s_d.aw_got && !s_d.bvalid;
      s_d.wready = !s_d.w_got && !s_d.bvalid;
      s_d.arready = !s_d.rvalid;
   end

   // ----------------------------------------
   // Registers
   // ----------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_q <= '0;
         s_q.ctl0 <= pir_adv_pkg::CFG_RESET;
      end else if (ce) begin
         s_q <= s_d;
      end
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   assign awready = s_q.awready;
   assign wready = s_q.wready;
   assign bvalid = s_q.bvalid;
   assign bresp = s_q.bresp;
   assign arready = s_q.arready;
   assign rvalid = s_q.rvalid;
   assign rresp = s_q.rresp;
   assign rdata = {24'h000000, s_q.rdata};
   assign vref_external = s_q.ctl0[pir_adv_pkg::B_VREF];
   assign vref_internal_1v = s_q.vref_int;
   assign buffer_refresh = s_q.refresh;
   assign wl_scan = s_q.scan;
   assign wl_event = s_q.event_p;
   assign wl_jammed = s_q.jam;
   assign window_lock_control = s_q.win;
   assign sample_averaging_amount = s_q.avg;
   assign motion_debounce_time = s_q.dbt;
   assign debounce_out_of_window_mask = s_q.dbm;
   assign transient_sensitivity_level = s_q.trs;
   assign noise_sensitivity_level = s_q.noi;
   assign extended_detector_sensitivity = s_q.exs;
   assign extended_detector_timeout = s_q.ext;

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   sequence s_no_scan4;
      !wl_scan [*4];
   endsequence

   property p_rev;
      rvalid && s_q.ar_idx == pir_adv_pkg::IDX_REV |-> rdata[7:0] == REVISION;
   endproperty
   a_rev: assert property (p_rev) else $error("revision readback wrong");

   property p_vref;
      ce && s_q.aw_got && s_q.w_got && !bvalid && s_q.w_lane && s_q.aw_idx == pir_adv_pkg::IDX_CTL0
         |=> vref_external == $past(s_q.w_byte[7]);
   endproperty
   a_vref: assert property (p_vref) else $error("reference select not written");

   property p_wl_flag;
      wl_event |-> s_q.ctl0[pir_adv_pkg::B_WLDET];
   endproperty
   a_wl_flag: assert property (p_wl_flag) else $error("white-light flag not set");

   property p_jam;
      ce && wl_jammed |=> !wl_event;
   endproperty
   a_jam: assert property (p_jam) else $error("event passed while jammed");

   property p_refresh;
      ce && engine_init && s_q.ctl0[pir_adv_pkg::B_REFR] |=> buffer_refresh;
   endproperty
   a_refresh: assert property (p_refresh) else $error("refresh not issued");

   property p_new;
      ce && sample_valid |=> s_q.ctl0[pir_adv_pkg::B_NEW] && s_q.smp == $past(sample_in);
   endproperty
   a_new: assert property (p_new) else $error("new sample not flagged");

   property p_origin;
      ce && motion_detect |=> s_q.ctl0[pir_adv_pkg::B_ORIG] == $past(motion_extended);
   endproperty
   a_origin: assert property (p_origin) else $error("detector origin wrong");

   property p_trans;
      ce && transient_event |=> s_q.ctl0[pir_adv_pkg::B_TRANS];
   endproperty
   a_trans: assert property (p_trans) else $error("transient flag lost");

   property p_noise;
      ce && noise_event |=> s_q.ctl0[pir_adv_pkg::B_NOISE];
   endproperty
   a_noise: assert property (p_noise) else $error("noise flag lost");

   property p_scan;
      ce && wl_scan |=> s_no_scan4;
   endproperty
   a_scan: assert property (p_scan) else $error("scans too close");

   property p_cap;
      ce |=> s_q.cap == $past(capacity_in);
   endproperty
   a_cap: assert property (p_cap) else $error("capacity not tracked");
endmodule : pir_adv_regs

/* File: bench/pir_engine_model.sv */
/*
 * Engine-side model: samples, scan answers, event pulses.
 * Assumes the aclk domain of the block.
 */
`timescale 1ns/1ps
module pir_engine_model #(
   parameter logic [15:0] CAP = 16'h1234,
   parameter logic [15:0] DC = 16'h5678
) (
   // Clock and scan request
   input wire logic aclk,
   input wire logic wl_scan,
   // Engine outputs
   output logic engine_init,
   output logic constructed_sample,
   output logic wl_result_valid,
   output logic wl_above_threshold,
   output logic wl_threshold_zero,
   output logic sample_valid,
   output logic [15:0] sample_in,
   output logic [15:0] dc_offset_in,
   output logic [15:0] capacity_in,
   output logic motion_detect,
   output logic motion_extended,
   output logic transient_event,
   output logic noise_event
);
   // Board supplies a regulated external reference, in millivolts
   localparam int EXT_REF_MV = 1000;
   logic wl_levels[$];
   initial begin
      {engine_init, constructed_sample, wl_result_valid, wl_above_threshold} = 4'h0;
      {wl_threshold_zero, sample_valid, motion_detect, motion_extended} = 4'h0;
      {transient_event, noise_event} = 2'h0;
      sample_in = 16'h0000;
      dc_offset_in = DC;
      capacity_in = CAP;
   end
   // ----------------------------------------
   // Scan answers, level changes outside valid
   // ----------------------------------------
   always @(posedge aclk) begin
      if (wl_scan === 1'b1) begin
         wl_result_valid <= 1'b1;
         wl_above_threshold <= (wl_levels.size() > 0) ? wl_levels.pop_front() : 1'b0;
      end else begin
         wl_result_valid <= 1'b0;
         wl_above_threshold <= ~wl_above_threshold;
      end
      if (constructed_sample === 1'b1) begin
         capacity_in <= capacity_in + 16'h0001;
         dc_offset_in <= ~dc_offset_in;
      end
   end
   // ----------------------------------------
   // Stimulus tasks
   // ----------------------------------------
   task automatic run_samples(input int n);
      for (int i = 0; i < n; i++) begin
         @(posedge aclk);
         constructed_sample <= 1'b1;
         @(posedge aclk);
         constructed_sample <= 1'b0;
         repeat (2) @(posedge aclk);
      end
      repeat (8) @(posedge aclk);
   endtask : run_samples
   task automatic set_thr_zero(input logic v);
      @(posedge aclk);
      wl_threshold_zero <= v;
   endtask : set_thr_zero
   // Kinds: 0 init, 1 sample, 2 motion, 3 transient, 4 noise
   task automatic fire(input int kind, input logic [15:0] v);
      @(posedge aclk);
      case (kind)
         0: engine_init <= 1'b1;
         1: sample_valid <= 1'b1;
         2: motion_detect <= 1'b1;
         3: transient_event <= 1'b1;
         default: noise_event <= 1'b1;
      endcase
      sample_in <= v;
      motion_extended <= v[0];
      @(posedge aclk);
      {engine_init, sample_valid, motion_detect, transient_event, noise_event} <= 5'h00;
      sample_in <= ~v;
      repeat (2) @(posedge aclk);
   endtask : fire
endmodule : pir_engine_model

/* File: bench/test_pir_adv_regs.sv */
/*
 * Bench of the advanced register block: register table, then event scenarios.
 * Assumes the engine model drives the engine inputs.
 */
`timescale 1ns/1ps
module test_pir_adv_regs;
   typedef struct {logic [7:0] idx; logic [7:0] wv; logic [7:0] rv; logic [1:0] er;} row_t;
   localparam logic [7:0] REV = 8'h3C; // Arbitrary value
   localparam logic [1:0] OK = pir_adv_pkg::RESP_OKAY;
   localparam logic [7:0] CTL0 = pir_adv_pkg::IDX_CTL0, WLT = pir_adv_pkg::IDX_WLT;
   logic aclk = 1'b0;
   logic aresetn, ce, awvalid, wvalid, bready, arvalid, rready;
   logic [9:0] awaddr, araddr;
   logic [31:0] wdata, rdata;
   logic [3:0] wstrb;
   logic awready, wready, bvalid, arready, rvalid;
   logic [1:0] bresp, rresp;
   logic engine_init, constructed_sample, wl_result_valid, wl_above_threshold, wl_threshold_zero;
   logic sample_valid, motion_detect, motion_extended, transient_event, noise_event;
   logic [15:0] sample_in, dc_offset_in, capacity_in;
   logic vref_external, vref_internal_1v, buffer_refresh, wl_scan, wl_event, wl_jammed;
   logic [7:0] win_q, avg_q, dbt_q, dbm_q, exs_q, ext_q;
   logic [6:0] trs_q, noi_q;
   int err_count = 0, comparisons = 0, n_refresh = 0, n_scan = 0, n_event = 0, n0;
   logic [3:0] rates[3] = '{4'h0, 4'h1, 4'h3};
   row_t rows[15] = '{
      '{WLT, 8'hA5, 8'hA5, OK}, '{pir_adv_pkg::IDX_WIN, 8'h3C, 8'h3C, OK},
      '{pir_adv_pkg::IDX_AVG, 8'h77, 8'h77, OK}, '{pir_adv_pkg::IDX_DBT, 8'h81, 8'h81, OK},
      '{pir_adv_pkg::IDX_DBM, 8'h0F, 8'h0F, OK}, '{pir_adv_pkg::IDX_TRS, 8'hFF, pir_adv_pkg::SENS_MASK, OK},
      '{pir_adv_pkg::IDX_NOI, 8'hFF, pir_adv_pkg::SENS_MASK, OK}, '{pir_adv_pkg::IDX_EXS, 8'h12, 8'h12, OK},
      '{pir_adv_pkg::IDX_EXT, 8'h34, 8'h34, OK}, '{pir_adv_pkg::IDX_REV, 8'h00, REV, OK},
      '{pir_adv_pkg::IDX_CAP_H, 8'h00, 8'h12, OK}, '{pir_adv_pkg::IDX_CAP_L, 8'h00, 8'h34, OK},
      '{pir_adv_pkg::IDX_DC_H, 8'h00, 8'h56, OK}, '{pir_adv_pkg::IDX_DC_L, 8'h00, 8'h78, OK},
      '{8'h10, 8'h55, 8'h00, pir_adv_pkg::RESP_SLVERR}};
   always #50 aclk = ~aclk;
   pir_adv_regs #(.REVISION(REV)) i_pir_adv_regs (
      .aclk, .aresetn, .ce, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid,
      .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .engine_init, .constructed_sample,
      .wl_result_valid, .wl_above_threshold, .wl_threshold_zero, .sample_valid, .sample_in, .dc_offset_in,
      .capacity_in, .motion_detect, .motion_extended, .transient_event, .noise_event, .vref_external,
      .vref_internal_1v, .buffer_refresh, .wl_scan, .wl_event, .wl_jammed, .window_lock_control(win_q),
      .sample_averaging_amount(avg_q), .motion_debounce_time(dbt_q), .debounce_out_of_window_mask(dbm_q),
      .transient_sensitivity_level(trs_q), .noise_sensitivity_level(noi_q),
      .extended_detector_sensitivity(exs_q), .extended_detector_timeout(ext_q));
   pir_engine_model i_pir_engine_model (
      .aclk, .wl_scan, .engine_init, .constructed_sample, .wl_result_valid, .wl_above_threshold,
      .wl_threshold_zero, .sample_valid, .sample_in, .dc_offset_in, .capacity_in, .motion_detect,
      .motion_extended, .transient_event, .noise_event);
   // Pulse counters
   always @(posedge aclk) begin
      if (buffer_refresh === 1'b1) n_refresh++;
      if (wl_scan === 1'b1) n_scan++;
      if (wl_event === 1'b1) n_event++;
   end
   // ----------------------------------------
   // Check, bus, engine stimulus and closing tasks
   // ----------------------------------------
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         err_count++;
         $display("BAD at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic wr(input logic [7:0] idx, input logic [7:0] d, input logic [1:0] er);
      logic aw_ok, w_ok, b_ok;
      int n;
      {aw_ok, w_ok, b_ok} = 3'b000;
      n = 0;
      @(posedge aclk);
      awaddr <= {idx, 2'b00};
      wdata <= {24'h0, d};
      wstrb <= {4{|d}};
      {awvalid, wvalid, bready} <= 3'b111;
      while (!b_ok && n < 100) begin
         @(posedge aclk);
         n++;
         if (aw_ok && w_ok && bvalid === 1'b1) begin
            b_ok = 1'b1;
            bready <= 1'b0;
            chk({30'h0, bresp}, {30'h0, er});
         end
         if (!aw_ok && awready === 1'b1) begin
            aw_ok = 1'b1;
            awvalid <= 1'b0;
         end
         if (!w_ok && wready === 1'b1) begin
            w_ok = 1'b1;
            wvalid <= 1'b0;
         end
      end
      chk({31'h0, b_ok}, 32'h1);
   endtask : wr
   task automatic rd_chk(input logic [7:0] idx, input logic [7:0] exp, input logic [1:0] er);
      logic ar_ok, r_ok;
      int n;
      {ar_ok, r_ok} = 2'b00;
      n = 0;
      @(posedge aclk);
      araddr <= {idx, 2'b00};
      {arvalid, rready} <= 2'b11;
      while (!r_ok && n < 100) begin
         @(posedge aclk);
         n++;
         if (ar_ok && rvalid === 1'b1) begin
            r_ok = 1'b1;
            rready <= 1'b0;
            chk(rdata, {24'h0, exp});
            chk({30'h0, rresp}, {30'h0, er});
         end
         if (!ar_ok && arready === 1'b1) begin
            ar_ok = 1'b1;
            arvalid <= 1'b0;
         end
      end
      chk({31'h0, r_ok}, 32'h1);
   endtask : rd_chk
   task automatic ev(input int k, input logic [15:0] v);
      i_pir_engine_model.fire(k, v);
   endtask : ev
   task automatic run(input int n);
      i_pir_engine_model.run_samples(n);
   endtask : run
   task automatic wrap_up();
      $display("Comparisons %0d, mismatches %0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : wrap_up
   initial begin
      #2000000;
      err_count++;
      wrap_up();
   end
   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
      ce = 1'b1;
      {awaddr, araddr, wstrb} = 24'h000000;
      wdata = 32'h0;
      repeat (20) @(posedge aclk);
      aresetn <= 1'b1;
      foreach (rows[i]) begin
         wr(rows[i].idx, rows[i].wv, rows[i].er);
         rd_chk(rows[i].idx, rows[i].rv, rows[i].er);
      end
      wr(pir_adv_pkg::IDX_AVG, 8'h00, OK);
      chk({avg_q, dbm_q, exs_q, ext_q}, 32'h770F1234);
      chk({win_q, dbt_q, 1'b0, trs_q, 1'b0, noi_q}, 32'h3C817F7F);
      ev(0, 16'h0000);
      rd_chk(WLT, 8'hA5, OK);
      chk({31'h0, vref_internal_1v}, 32'h1);
      n0 = n_refresh;
      wr(CTL0, 8'hB0, OK);
      chk({31'h0, vref_external}, 32'h1);
      ev(0, 16'h0000);
      chk(n_refresh - n0, 1);
      wr(CTL0, 8'hA0, OK);
      ev(0, 16'h0000);
      chk(n_refresh - n0, 1);
      ev(1, 16'hCAFE);
      ev(3, 16'h0000);
      ev(4, 16'h0000);
      ev(2, 16'h0001);
      rd_chk(CTL0, 8'hAF, OK);
      rd_chk(pir_adv_pkg::IDX_SMP_H, 8'hCA, OK);
      rd_chk(pir_adv_pkg::IDX_SMP_L, 8'hFE, OK);
      wr(CTL0, 8'hA0, OK);
      rd_chk(CTL0, 8'hA4, OK);
      ce <= 1'b0;
      ev(3, 16'h0000);
      ce <= 1'b1;
      ev(2, 16'h0000);
      rd_chk(CTL0, 8'hA0, OK);
      wr(CTL0, 8'h80, OK);
      foreach (rates[i]) begin
         wr(WLT, {4'h1, rates[i]}, OK);
         run(20);
         n0 = n_scan;
         run(60);
         chk(n_scan - n0, 60 / (int'(pir_adv_pkg::WL_SCAN_STEP) * (int'(rates[i]) + 1)));
      end
      wr(WLT, 8'h30, OK);
      i_pir_engine_model.set_thr_zero(1'b1);
      n0 = n_scan;
      run(30);
      chk(n_scan - n0, 0);
      i_pir_engine_model.set_thr_zero(1'b0);
      n0 = n_event;
      repeat (2) i_pir_engine_model.wl_levels.push_back(1'b1);
      run(30);
      chk(n_event - n0, 0);
      rd_chk(CTL0, 8'h80, OK);
      repeat (3) i_pir_engine_model.wl_levels.push_back(1'b1);
      run(30);
      chk(n_event - n0, 1);
      rd_chk(CTL0, 8'hC0, OK);
      wr(CTL0, 8'h80, OK);
      rd_chk(CTL0, 8'h80, OK);
      wr(CTL0, 8'hA0, OK);
      wr(WLT, 8'h10, OK);
      n0 = n_event;
      repeat (14) i_pir_engine_model.wl_levels.push_back(1'b1);
      run(75);
      chk(n_event - n0, {28'h0, pir_adv_pkg::JAM_EVENTS});
      chk({31'h0, wl_jammed}, 32'h1);
      run(int'(pir_adv_pkg::JAM_QUIET) + 30);
      chk({31'h0, wl_jammed}, 32'h0);
      @(posedge aclk);
      aresetn <= 1'b0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      rd_chk(WLT, pir_adv_pkg::CFG_RESET, OK);
      rd_chk(CTL0, pir_adv_pkg::CFG_RESET, OK);
      wrap_up();
   end
endmodule : test_pir_adv_regs
